//--- rtl/uv_pkg.sv
// constants, types and helpers shared by the input undervoltage supervisor
package uv_pkg;

  // ************************************************************
  // clock and widths
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int UNIT_W = 16;
  localparam int DLY_W = 23;

  // ************************************************************
  // command codes of the two registers
  // ************************************************************
  localparam logic [7:0] CMD_UV_LIMIT = 8'h59;
  localparam logic [7:0] CMD_UV_ACTION = 8'h5A;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] UV_LIMIT_RST = 16'h0000;
  localparam logic [7:0] UV_ACTION_RST = 8'h00;

  // ************************************************************
  // field codes of the action byte
  // ************************************************************
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_CONTINUE = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // action byte: response 7:6, retries 5:3, delay exponent 2:0
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] delay;
  } uv_action_t;

  // command port from the serial host interface
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } uv_cmd_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_RETRY = 2'b10,
    ST_LATCH = 2'b11
  } uv_state_t;

  // linear word (5-bit exponent, 11-bit mantissa) to fixed point, 16 fraction bits
  function automatic logic signed [47:0] lin_to_fx(input logic [15:0] v);
    logic signed [47:0] mant;
    logic [4:0] sh;
    mant = 48'(signed'(v[10:0]));
    sh = v[15:11] ^ 5'h10;
    return mant <<< sh;
  endfunction

endpackage

//--- rtl/delay_timer.sv
// down-counter that marks the end of a programmed delay
module delay_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic cancel,
  input wire logic [uv_pkg::DLY_W-1:0] cycles,
  output logic done
);

  logic [uv_pkg::DLY_W-1:0] cnt_ff;
  logic busy_ff;

  // ************************************************************
  // count
  // ************************************************************
  // load wins over cancel so a restart never gets lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      if (load) begin
        cnt_ff <= cycles;
        busy_ff <= 1'b1;
      end else if (cancel || done) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // done lands exactly cycles clocks after the load
  assign done = busy_ff && (cnt_ff == {{(uv_pkg::DLY_W-1){1'b0}}, 1'b1});

endmodule

//--- rtl/uv_fault_supervisor.sv
// input undervoltage fault supervisor: threshold, response, retries and delays
// Functional notes
// [RULE1] hold the undervoltage threshold as a 16-bit linear word in volts
// [RULE2] flag a fault while measured input is below threshold, then respond
// [RULE3] response 00: ignore the fault, output keeps running
// [RULE4] response 01: keep running for the delay, then follow retry setting
// [RULE5] response 10: disable output at once, then follow retry setting
// [RULE6] response 11: disable output until a clearing event
// [RULE7] clearing the status bit alone releases the latched disable
// [RULE8] the clear-faults command releases the latched disable
// [RULE9] reset clears any latched undervoltage fault
// [RULE10] commanding output off then on releases the latched disable
// [RULE11] retry code 000: no restart, output stays off until cleared
// [RULE12] retry codes 001 to 110: 1 to 6 attempts, then latch off
// [RULE13] retry code 111: retry until off command, reset or other shutdown
// [RULE14] restart attempts are spaced by the delay times the time unit
// [RULE15] delay field is hold time or retry spacing, by response
// [RULE16] delay field n selects two to the n time units
// [RULE17] time unit length comes from a separate register input
module uv_fault_supervisor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire uv_pkg::uv_cmd_t cmd,
  input wire logic [15:0] vin_meas,
  input wire logic [uv_pkg::UNIT_W-1:0] delay_unit_cycles,
  input wire logic ctrl_pin,
  input wire logic operation_on,
  input wire logic clear_faults,
  input wire logic clear_uv_status,
  input wire logic other_shutdown,
  output logic [15:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic rd_nack_ff,
  output logic out_enable_ff,
  output logic uv_status_ff,
  output logic latched_off_ff,
  output logic [2:0] attempt_ff
);

  logic rst_meta_ff;
  logic rst_ok_ff;
  logic ctrl_meta_ff;
  logic ctrl_sync_ff;
  logic on_ff;
  logic [15:0] limit_ff;
  uv_pkg::uv_action_t act_ff;
  uv_pkg::uv_state_t state_ff;
  uv_pkg::uv_state_t nxt_state;
  logic [2:0] nxt_attempt;
  logic on_now;
  logic turn_on;
  logic uv_now;
  logic clear_latch;
  logic timer_load;
  logic timer_cancel;
  logic timer_done;
  logic [uv_pkg::UNIT_W-1:0] unit_eff;
  logic [uv_pkg::DLY_W-1:0] dly_cycles;
  uv_pkg::uv_state_t retry_entry;
  logic wr_hit;
  logic rd_hit;
  logic [uv_pkg::DLY_W-1:0] dly_cnt_ff;
  logic [uv_pkg::DLY_W-1:0] dly_exp_ff;

  // ************************************************************
  // reset release and pin synchroniser
  // ************************************************************
  // reset release runs without ce so a frozen block still leaves reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_ok_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_ok_ff <= rst_meta_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      ctrl_meta_ff <= 1'b0;
      ctrl_sync_ff <= 1'b0;
    end else if (ce) begin
      ctrl_meta_ff <= ctrl_pin;
      ctrl_sync_ff <= ctrl_meta_ff;
    end
  end

  // ************************************************************
  // on/off command and clearing events
  // ************************************************************
  // output is on only while both the pin and the operation command agree
  assign on_now = ctrl_sync_ff && operation_on;
  assign turn_on = on_now && !on_ff;
  assign clear_latch = clear_faults || clear_uv_status || turn_on; // [RULE7] [RULE8] [RULE10]

  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      on_ff <= 1'b0;
    end else if (ce) begin
      on_ff <= on_now;
    end
  end

  // ************************************************************
  // register writes and reads
  // ************************************************************
  assign wr_hit = cmd.valid && cmd.write;
  assign rd_hit = cmd.valid && !cmd.write;

  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      limit_ff <= uv_pkg::UV_LIMIT_RST;
      act_ff <= uv_pkg::UV_ACTION_RST;
    end else if (ce && wr_hit) begin
      if (cmd.code == uv_pkg::CMD_UV_LIMIT) begin
        limit_ff <= cmd.wdata; // [RULE1]
      end
      if (cmd.code == uv_pkg::CMD_UV_ACTION) begin
        act_ff <= cmd.wdata[7:0];
      end
    end
  end

  // unknown codes answer with a nack and zero data
  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
      rd_nack_ff <= 1'b0;
    end else if (ce) begin
      rd_valid_ff <= rd_hit;
      rd_nack_ff <= cmd.valid && (cmd.code != uv_pkg::CMD_UV_LIMIT)
                    && (cmd.code != uv_pkg::CMD_UV_ACTION);
      if (rd_hit && cmd.code == uv_pkg::CMD_UV_LIMIT) begin
        rd_data_ff <= limit_ff;
      end else if (rd_hit && cmd.code == uv_pkg::CMD_UV_ACTION) begin
        rd_data_ff <= {8'h00, act_ff};
      end else begin
        rd_data_ff <= 16'h0000;
      end
    end
  end

  // ************************************************************
  // fault detection and status
  // ************************************************************
  // signed compare of both linear words after scaling to fixed point
  assign uv_now = uv_pkg::lin_to_fx(vin_meas) < uv_pkg::lin_to_fx(limit_ff); // [RULE2]

  // a new fault in the clearing cycle keeps the bit set
  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      uv_status_ff <= 1'b0;
    end else if (ce) begin
      if (uv_now) begin
        uv_status_ff <= 1'b1; // [RULE2]
      end else if (clear_faults || clear_uv_status) begin
        uv_status_ff <= 1'b0; // [RULE7] [RULE8]
      end
    end
  end

  // ************************************************************
  // delay length
  // ************************************************************
  // a zero unit would wrap the timer to 2^23 cycles, so it is treated as one cycle
  assign unit_eff = (delay_unit_cycles == '0) ? 16'h0001 : delay_unit_cycles; // [RULE17]
  assign dly_cycles = uv_pkg::DLY_W'(unit_eff) << act_ff.delay; // [RULE15] [RULE16]
  assign retry_entry = (act_ff.retries == uv_pkg::RETRY_NONE) ?
                       uv_pkg::ST_LATCH : uv_pkg::ST_RETRY; // [RULE11]

  delay_timer u_timer (
    .clock(clock),
    .rst_n(rst_ok_ff),
    .ce(ce),
    .load(timer_load),
    .cancel(timer_cancel),
    .cycles(dly_cycles),
    .done(timer_done)
  );

  // ************************************************************
  // response state machine
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_attempt = attempt_ff;
    timer_load = 1'b0;
    timer_cancel = 1'b0;
    unique case (state_ff)
      uv_pkg::ST_RUN: begin
        if (on_now && uv_now) begin
          unique case (act_ff.resp)
            uv_pkg::RESP_IGNORE: begin
              nxt_state = uv_pkg::ST_RUN; // [RULE3]
            end
            uv_pkg::RESP_CONTINUE: begin
              nxt_state = uv_pkg::ST_HOLD; // [RULE4]
              timer_load = 1'b1;
            end
            uv_pkg::RESP_DISABLE: begin
              nxt_state = retry_entry; // [RULE5]
              nxt_attempt = 3'h0;
              timer_load = 1'b1;
            end
            uv_pkg::RESP_LATCH: begin
              nxt_state = uv_pkg::ST_LATCH; // [RULE6]
            end
          endcase
        end
      end
      uv_pkg::ST_HOLD: begin
        if (!uv_now) begin
          nxt_state = uv_pkg::ST_RUN;
          timer_cancel = 1'b1;
        end else if (timer_done) begin
          nxt_state = retry_entry; // [RULE4]
          nxt_attempt = 3'h0;
          timer_load = 1'b1;
        end
      end
      uv_pkg::ST_RETRY: begin
        if (other_shutdown) begin
          nxt_state = uv_pkg::ST_LATCH; // [RULE13]
          timer_cancel = 1'b1;
        end else if (timer_done) begin
          // an attempt succeeds when the input is back above threshold
          nxt_attempt = attempt_ff + 3'h1;
          if (!uv_now) begin
            nxt_state = uv_pkg::ST_RUN;
          end else if (act_ff.retries != uv_pkg::RETRY_FOREVER
                       && nxt_attempt >= act_ff.retries) begin
            nxt_state = uv_pkg::ST_LATCH; // [RULE12]
          end else begin
            timer_load = 1'b1; // [RULE13] [RULE14]
          end
        end
      end
      uv_pkg::ST_LATCH: begin
        if (clear_latch) begin
          nxt_state = uv_pkg::ST_RUN; // [RULE6] [RULE7] [RULE8] [RULE10]
          nxt_attempt = 3'h0;
        end
      end
    endcase
    // an off command stops retrying; a latch waits for the off-on edge
    if (!on_now && state_ff != uv_pkg::ST_LATCH) begin
      nxt_state = uv_pkg::ST_RUN; // [RULE13]
      nxt_attempt = 3'h0;
      timer_load = 1'b0;
      timer_cancel = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      state_ff <= uv_pkg::ST_RUN; // [RULE9]
      attempt_ff <= 3'h0;
    end else if (ce) begin
      state_ff <= nxt_state;
      attempt_ff <= nxt_attempt;
    end
  end

  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      out_enable_ff <= 1'b0;
      latched_off_ff <= 1'b0; // [RULE9]
    end else if (ce) begin
      out_enable_ff <= on_now && (nxt_state == uv_pkg::ST_RUN
                                  || nxt_state == uv_pkg::ST_HOLD); // [RULE3] [RULE5]
      latched_off_ff <= nxt_state == uv_pkg::ST_LATCH;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // helper: cycles spent since the last delay load, and the length expected
  always_ff @(posedge clock or negedge rst_ok_ff) begin
    if (!rst_ok_ff) begin
      dly_cnt_ff <= '0;
      dly_exp_ff <= '0;
    end else if (ce) begin
      if (timer_load) begin
        dly_cnt_ff <= '0;
        dly_exp_ff <= uv_pkg::DLY_W'(unit_eff * (24'h000001 << act_ff.delay));
      end else begin
        dly_cnt_ff <= dly_cnt_ff + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_ok_ff);

  sequence s_run_fault;
    ce && state_ff == uv_pkg::ST_RUN && on_now && uv_now;
  endsequence

  sequence s_limit_write;
    ce && wr_hit && cmd.code == uv_pkg::CMD_UV_LIMIT;
  endsequence

  sequence s_limit_read;
    ce && rd_hit && cmd.code == uv_pkg::CMD_UV_LIMIT;
  endsequence

  property p_limit_hold;
    s_limit_write ##1 s_limit_read |=> rd_valid_ff && rd_data_ff == $past(cmd.wdata, 2);
  endproperty
  a_limit_hold: assert property (p_limit_hold) else $error("threshold not read back"); // [RULE1]

  property p_status_set;
    ce && uv_now |=> uv_status_ff;
  endproperty
  a_status_set: assert property (p_status_set) else $error("fault not flagged"); // [RULE2]

  property p_ignore;
    s_run_fault and (act_ff.resp == uv_pkg::RESP_IGNORE) |=> out_enable_ff;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored fault disabled output"); // [RULE3]

  property p_hold;
    s_run_fault and (act_ff.resp == uv_pkg::RESP_CONTINUE)
      |=> out_enable_ff && state_ff == uv_pkg::ST_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("output not kept on during hold"); // [RULE4]

  property p_disable;
    s_run_fault and (act_ff.resp == uv_pkg::RESP_DISABLE) |=> !out_enable_ff;
  endproperty
  a_disable: assert property (p_disable) else $error("output not disabled at once"); // [RULE5]

  property p_latch_keep;
    ce && state_ff == uv_pkg::ST_LATCH && !clear_latch
      |=> state_ff == uv_pkg::ST_LATCH && !out_enable_ff;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch left without clear"); // [RULE6]

  property p_clear_bit;
    ce && state_ff == uv_pkg::ST_LATCH && clear_uv_status |=> state_ff != uv_pkg::ST_LATCH;
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit clear kept latch"); // [RULE7]

  property p_clear_all;
    ce && state_ff == uv_pkg::ST_LATCH && clear_faults |=> state_ff != uv_pkg::ST_LATCH;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear faults kept latch"); // [RULE8]

  property p_turn_on;
    ce && state_ff == uv_pkg::ST_LATCH && turn_on |=> state_ff == uv_pkg::ST_RUN;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("off-on kept latch"); // [RULE10]

  property p_no_retry;
    s_run_fault and (act_ff.resp == uv_pkg::RESP_DISABLE
      && act_ff.retries == uv_pkg::RETRY_NONE) |=> state_ff == uv_pkg::ST_LATCH;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("retry 000 did not latch"); // [RULE11]

  property p_limit_reached;
    ce && state_ff == uv_pkg::ST_RETRY && timer_done && uv_now && on_now
      && !other_shutdown && act_ff.retries != uv_pkg::RETRY_FOREVER
      && attempt_ff + 3'h1 == act_ff.retries |=> state_ff == uv_pkg::ST_LATCH;
  endproperty
  a_limit_reached: assert property (p_limit_reached) else $error("no latch at limit"); // [RULE12]

  property p_forever;
    ce && state_ff == uv_pkg::ST_RETRY && act_ff.retries == uv_pkg::RETRY_FOREVER
      && on_now && !other_shutdown |=> state_ff != uv_pkg::ST_LATCH;
  endproperty
  a_forever: assert property (p_forever) else $error("endless retry latched"); // [RULE13]

  property p_spacing;
    ce && timer_done && (state_ff == uv_pkg::ST_RETRY || state_ff == uv_pkg::ST_HOLD)
      |-> dly_cnt_ff + 1'b1 == dly_exp_ff;
  endproperty
  a_spacing: assert property (p_spacing) else $error("delay length wrong"); // [RULE14] [RULE16]

endmodule

//--- test/host_model.sv
// host controller model: register commands and fault clearing
module host_model (
  input wire logic clock,
  input wire logic [15:0] rd_data_ff,
  input wire logic rd_valid_ff,
  input wire logic rd_nack_ff,
  output uv_pkg::uv_cmd_t cmd,
  output logic clear_faults,
  output logic clear_uv_status,
  output logic operation_on
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd = '0;
    clear_faults = 1'b0;
    clear_uv_status = 1'b0;
    operation_on = 1'b1;
  end

  // ************************************************************
  // one command per call, gap gives a slow host
  // ************************************************************
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
      input int gap, output logic [15:0] data, output logic nack);
    int n;
    @(negedge clock);
    repeat (gap) @(negedge clock);
    cmd.valid = 1'b1;
    cmd.write = wr;
    cmd.code = code;
    cmd.wdata = wdata;
    @(posedge clock);
    @(negedge clock);
    cmd.valid = 1'b0;
    // released bus must not keep showing the old word
    cmd.code = ~code;
    cmd.wdata = ~wdata;
    for (n = 0; n < 3; n++) begin
      if (rd_valid_ff === 1'b1 || rd_nack_ff === 1'b1) break;
      @(negedge clock);
    end
    data = rd_data_ff;
    nack = rd_nack_ff;
  endtask

  // ************************************************************
  // clearing events: 0 status bit, 1 clear all, 2 off then on
  // ************************************************************
  task automatic pulse(input int kind);
    @(negedge clock);
    case (kind)
      0: clear_uv_status = 1'b1;
      1: clear_faults = 1'b1;
      default: operation_on = 1'b0;
    endcase
    @(negedge clock);
    clear_uv_status = 1'b0;
    clear_faults = 1'b0;
    operation_on = 1'b1;
  endtask

  // ************************************************************
  // write then read of one code on two edges in a row
  // ************************************************************
  task automatic write_read(input logic [7:0] code, input logic [15:0] wdata,
      output logic [15:0] data);
    @(negedge clock);
    cmd.valid = 1'b1;
    cmd.write = 1'b1;
    cmd.code = code;
    cmd.wdata = wdata;
    @(negedge clock);
    cmd.write = 1'b0;
    @(negedge clock);
    data = rd_data_ff;
    cmd.valid = 1'b0;
    cmd.code = ~code;
    cmd.wdata = ~wdata;
  endtask
endmodule

//--- test/uv_fault_supervisor_tb.sv
// self-checking bench of the undervoltage fault supervisor
module uv_fault_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] VIN_OK = 16'h0030;
  localparam logic [15:0] VIN_LOW = 16'h0020;
  localparam logic [15:0] LIMIT = 16'h0028;

  logic clock, rstn, ce, ctrl_pin, other_shutdown;
  logic [15:0] vin_meas, delay_unit_cycles, rd_data_ff;
  logic rd_valid_ff, rd_nack_ff, out_enable_ff, uv_status_ff, latched_off_ff;
  logic clear_faults, clear_uv_status, operation_on;
  logic [2:0] attempt_ff;
  uv_pkg::uv_cmd_t cmd;
  int failures = 0;
  int checks = 0;

  uv_fault_supervisor uut (.clock(clock), .rstn(rstn), .ce(ce), .cmd(cmd),
    .vin_meas(vin_meas), .delay_unit_cycles(delay_unit_cycles), .ctrl_pin(ctrl_pin),
    .operation_on(operation_on), .clear_faults(clear_faults),
    .clear_uv_status(clear_uv_status), .other_shutdown(other_shutdown),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .rd_nack_ff(rd_nack_ff),
    .out_enable_ff(out_enable_ff), .uv_status_ff(uv_status_ff),
    .latched_off_ff(latched_off_ff), .attempt_ff(attempt_ff));

  host_model host (.clock(clock), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
    .rd_nack_ff(rd_nack_ff), .cmd(cmd), .clear_faults(clear_faults),
    .clear_uv_status(clear_uv_status), .operation_on(operation_on));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic [15:0] d;
    logic nk;
    host.access(1'b1, code, data, 0, d, nk);
    check("write nack", 16'h0000, 16'(nk));
  endtask

  task automatic rd_chk(input string name, input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic nk;
    host.access(1'b0, code, 16'h0000, 0, d, nk);
    check(name, exp, d);
  endtask

  // bounded wait on output enable (0) or latch (1); n counts falling edges
  task automatic wait_sig(input string name, input int which, input logic val,
      input int maxc, output int n);
    logic s;
    for (n = 0; n <= maxc; n++) begin
      s = (which == 0) ? out_enable_ff : latched_off_ff;
      if (s === val) break;
      @(negedge clock);
    end
    if (n > maxc) check(name, 16'(val), 16'(~val));
  endtask

  // clears the last fault, then programs limit and action
  task automatic arm(input logic [7:0] act);
    vin_meas = VIN_OK;
    host.pulse(1);
    wr(uv_pkg::CMD_UV_LIMIT, LIMIT);
    wr(uv_pkg::CMD_UV_ACTION, {8'h00, act});
    repeat (4) @(negedge clock);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    logic [15:0] d;
    logic nk;
    int n;
    rstn = 1'b0;
    ce = 1'b1;
    ctrl_pin = 1'b1;
    other_shutdown = 1'b0;
    vin_meas = VIN_OK;
    delay_unit_cycles = 16'h0002;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (3) @(negedge clock);
    rd_chk("limit reset", uv_pkg::CMD_UV_LIMIT, uv_pkg::UV_LIMIT_RST);
    rd_chk("action reset", uv_pkg::CMD_UV_ACTION, uv_pkg::UV_ACTION_RST);
    host.access(1'b1, 8'h5B, 16'h1234, 2, d, nk);
    check("unknown code nack", 16'h0001, 16'(nk));
    host.write_read(uv_pkg::CMD_UV_LIMIT, 16'h0345, d);
    check("limit back to back", 16'h0345, d);
    wr(uv_pkg::CMD_UV_LIMIT, 16'hF7FF);
    rd_chk("limit", uv_pkg::CMD_UV_LIMIT, 16'hF7FF);
    // a write while the enable is low must not land
    ce = 1'b0;
    wr(uv_pkg::CMD_UV_LIMIT, 16'h1111);
    ce = 1'b1;
    rd_chk("frozen limit", uv_pkg::CMD_UV_LIMIT, 16'hF7FF);
    wr(uv_pkg::CMD_UV_ACTION, 16'hABCD);
    rd_chk("action", uv_pkg::CMD_UV_ACTION, 16'h00CD);
    // ignore mode: status only
    arm(8'h00);
    vin_meas = VIN_LOW;
    repeat (10) @(negedge clock);
    check("ignore enable", 16'h0001, 16'(out_enable_ff));
    check("ignore status", 16'h0001, 16'(uv_status_ff));
    // latch mode with every clearing event; 3 pin off-on, 4 reset
    for (int k = 0; k < 5; k++) begin
      arm(8'hC0);
      vin_meas = VIN_LOW;
      wait_sig("latch disable", 0, 1'b0, 4, n);
      vin_meas = VIN_OK;
      repeat (6) @(negedge clock);
      check("latched", 16'h0001, 16'(latched_off_ff));
      check("held off", 16'h0000, 16'(out_enable_ff));
      if (k < 3) host.pulse(k);
      if (k == 3) begin
        ctrl_pin = 1'b0;
        repeat (4) @(negedge clock);
        ctrl_pin = 1'b1;
      end
      if (k == 4) begin
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
      end
      wait_sig("release", 0, 1'b1, 10, n);
      check("unlatched", 16'h0000, 16'(latched_off_ff));
      if (k == 0) check("status cleared", 16'h0000, 16'(uv_status_ff));
    end
    // retry counts 0..6 with the fault persisting
    for (int r = 0; r < 7; r++) begin
      arm({2'b10, 3'(r), 3'h0});
      vin_meas = VIN_LOW;
      wait_sig("disable", 0, 1'b0, 4, n);
      repeat (r * 2 + 4) @(negedge clock);
      check("attempts", 16'(r), 16'(attempt_ff));
      if (r > 0) check("latch after retries", 16'h0001, 16'(latched_off_ff));
      vin_meas = VIN_OK;
      repeat (6) @(negedge clock);
      check("stays off", 16'h0000, 16'(out_enable_ff));
    end
    // attempt spacing: unit times two to the delay field
    for (int dl = 0; dl < 4; dl++) begin
      delay_unit_cycles = 16'(2 + dl);
      arm({2'b10, 3'h1, 3'(dl)});
      vin_meas = VIN_LOW;
      wait_sig("disable", 0, 1'b0, 4, n);
      wait_sig("spaced latch", 1, 1'b1, 60, n);
      check("spacing", 16'((2 + dl) << dl), 16'(n));
    end
    delay_unit_cycles = 16'h0002;
    // fault gone before the attempt: restart succeeds
    arm({2'b10, 3'h3, 3'h1});
    vin_meas = VIN_LOW;
    wait_sig("disable", 0, 1'b0, 4, n);
    vin_meas = VIN_OK;
    wait_sig("restart", 0, 1'b1, 12, n);
    check("no latch", 16'h0000, 16'(latched_off_ff));
    // keep running for the delay, then retry once
    arm({2'b01, 3'h1, 3'h2});
    vin_meas = VIN_LOW;
    wait_sig("hold end", 0, 1'b0, 14, n);
    check("hold length", 16'h0001, 16'(n >= 7 && n <= 10));
    wait_sig("hold latch", 1, 1'b1, 14, n);
    // endless retries never latch on their own; another fault stops them
    arm({2'b10, 3'h7, 3'h0});
    vin_meas = VIN_LOW;
    wait_sig("disable", 0, 1'b0, 4, n);
    repeat (40) @(negedge clock);
    check("no latch forever", 16'h0000, 16'(latched_off_ff));
    other_shutdown = 1'b1;
    wait_sig("shutdown latch", 1, 1'b1, 4, n);
    other_shutdown = 1'b0;
    arm(8'h00);
    report_and_stop();
  end
endmodule
